// ==== rtl/aux_pkg.sv ====
// Purpose: Shared constants for the auxiliary contact condition logic
// Assumes: 10 MHz control clock, AXI4-Lite register access
// Notes:   Offsets are byte addresses of 32-bit words
package aux_pkg;
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned FW             = 16;      // Frequency width
   localparam int unsigned IW             = 16;      // Current width
   localparam int unsigned NAUX           = 4;
   localparam int unsigned MODE_W         = 5;
   // Register map
   localparam logic [7:0] OFS_RELAY_SEL   = 8'h00;
   localparam logic [7:0] OFS_AUX_MODE    = 8'h04;
   localparam logic [7:0] OFS_FDT         = 8'h08;
   localparam logic [7:0] OFS_WARN        = 8'h0c;
   localparam logic [7:0] OFS_STATUS      = 8'h10;
   localparam logic [7:0] OFS_RATED       = 8'h14;
   localparam logic [2:0] RELAY_SEL_RST   = 3'h2;
   localparam logic [2:0] RELAY_BIT_LV    = 3'h1;
   localparam logic [2:0] RELAY_BIT_TRIP  = 3'h2;
   localparam logic [2:0] RELAY_BIT_RETRY = 3'h4;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;
   // Thermal overload: 110 % for 36 s alarm, 60 s trip
   localparam int unsigned OVL_PCT        = 110;
   localparam int unsigned ALARM_PCT      = 60;
   localparam int unsigned TRIP_S         = 60;
   localparam int unsigned ALARM_S        = 36;
   localparam int unsigned PCT_DIV        = 100;
   localparam int unsigned MS_PER_S       = 1000;
   localparam int unsigned TICK_MS        = 1;
   localparam int unsigned TICK_CYC       = CLK_HZ / MS_PER_S * TICK_MS;
   // Contact modes
   typedef enum logic [MODE_W-1:0] {
      M_NONE, M_ARRIVE, M_SPEC, M_BAND, M_LEVEL, M_LEVEL_N, M_WARN,
      M_THERMAL, M_STALL, M_BUS_HI, M_BUS_LO, M_HOT, M_LOST, M_RUN,
      M_STOP, M_STEADY, M_INV_LINE, M_COMM_LINE, M_SSEARCH, M_READY,
      M_MULTI
   } aux_mode_e;
endpackage

// ==== rtl/overload_timer.sv ====
// Purpose: Inverse-time drive overload accumulator with alarm and trip
// Assumes: One tick per millisecond from the caller
// Notes:   Heat grows by the square of the percent of rated current
`timescale 1ns/1ns
module overload_timer
   import aux_pkg::*;
#(
   parameter int unsigned TRIP_MS = TRIP_S * MS_PER_S
) (
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          nrst,
   // Measurements
   input  wire logic          tick,
   input  wire logic [IW-1:0] i_out,
   input  wire logic [IW-1:0] i_rated,
   // Results
   output logic               alarm,
   output logic               trip
);
   localparam int unsigned AW = 40;
   localparam logic [AW-1:0] FULL =
      AW'(TRIP_MS) * AW'(OVL_PCT) * AW'(OVL_PCT);
   localparam logic [AW-1:0] ALARM_LVL =
      AW'(TRIP_MS) * AW'(OVL_PCT) * AW'(OVL_PCT) * AW'(ALARM_PCT)
      / AW'(PCT_DIV);

   logic [AW-1:0] heat_r;
   logic [AW-1:0] heat_nxt;
   logic [AW-1:0] pct;
   logic          over;

   // Percent of rated; guard a zero rating
   assign pct  = (i_rated == '0) ? '0 :
                 (AW'(i_out) * AW'(PCT_DIV)) / AW'(i_rated);
   assign over = pct > AW'(OVL_PCT);
   // At exactly 110 % heat clears; just above it the trip lands near TRIP_MS; more current, sooner
   assign heat_nxt = !tick ? heat_r :
                     over ? ((heat_r + pct * pct >= FULL) ? FULL :
                             heat_r + pct * pct) :
                     '0;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         heat_r <= '0;
         alarm  <= 1'b0;
         trip   <= 1'b0;
      end else begin
         heat_r <= heat_nxt;
         alarm  <= heat_nxt >= ALARM_LVL;
         trip   <= trip | (heat_nxt >= FULL);
      end
   end
endmodule // overload_timer

// ==== rtl/aux_contact_condition_select.sv ====
// Purpose: Auxiliary contact condition select and fault relay logic
// Assumes: Frequencies in 0.01 Hz, currents in arbitrary units
// Notes:   Registers over AXI4-Lite; trip latches until reset
// Functional notes
// - Arrival closes within half bandwidth of reference
// - Contact follows its selected condition
// - Band mode closes within half bandwidth
// - Level mode hysteresis on accel and decel
// - Inverted level mode is the complement
// - Warning closes after level held warning time
// - Thermal alarm after 36 s above 110%
// - Inverse-time overload trips after one minute
// - Alarm at 60 percent of trip time
// - Stall, bus high, bus low, hot close
// - Lost reference closes contact
// - Run closes above start, not braking
// - Stop, steady, ready, speed search close
// - Line exchange enables speed catch
// - Exchange setup locked while running; the multi-motor force on the last output ignores the lock
// - Multi-motor forces an auxiliary output
// - Relay gives open and closed pairs
// - Bit 1 relays low-voltage trip
// - Bit 2 relays other trips, not inhibit
// - Bit 3 relays exhausted retries
// - Priority bit 1, then 2, then 3
// - Status shows contacts, outputs and relay
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module aux_contact_condition_select
   import aux_pkg::*;
#(
   parameter int unsigned TRIP_MS = TRIP_S * MS_PER_S
) (
   // Clock and reset
   input  wire logic            ref_clk,
   input  wire logic            nrst,
   // AXI4-Lite write
   input  wire logic [7:0]      s_awaddr,
   input  wire logic            s_awvalid,
   output logic                 s_awready,
   input  wire logic [31:0]     s_wdata,
   input  wire logic [3:0]      s_wstrb,
   input  wire logic            s_wvalid,
   output logic                 s_wready,
   output logic [1:0]           s_bresp,
   output logic                 s_bvalid,
   input  wire logic            s_bready,
   // AXI4-Lite read
   input  wire logic [7:0]      s_araddr,
   input  wire logic            s_arvalid,
   output logic                 s_arready,
   output logic [31:0]          s_rdata,
   output logic [1:0]           s_rresp,
   output logic                 s_rvalid,
   input  wire logic            s_rready,
   // Drive state, same clock domain
   input  wire logic [FW-1:0]   ref_freq,
   input  wire logic [FW-1:0]   out_freq,
   input  wire logic            accelerating,
   input  wire logic [IW-1:0]   out_current,
   input  wire logic            stall_active,
   input  wire logic            dc_bus_high_flag,
   input  wire logic            dc_bus_low_flag,
   input  wire logic            heatsink_hot_flag,
   input  wire logic            ref_lost,
   input  wire logic            running,
   input  wire logic            dc_braking,
   input  wire logic            dc_start_preheat,
   input  wire logic            auto_tuning,
   input  wire logic            at_steady,
   input  wire logic            ready_to_run,
   input  wire logic            speed_searching,
   input  wire logic            exchanging,
   input  wire logic            multi_motor_sel,
   input  wire logic            multi_motor_out,
   input  wire logic [2:0]      ctrl_outputs,
   // Fault inputs
   input  wire logic            fault_lv,
   input  wire logic            fault_other,
   input  wire logic            output_inhibit,
   input  wire logic            retry_exhausted,
   input  wire logic            auto_retry_on,
   // Contacts and relay
   output logic [NAUX-1:0]      aux_contact,
   output logic                 fault_relay_no_side,
   output logic                 fault_relay_nc_side,
   output logic                 speed_catch_setting,
   output logic                 drive_thermal_alarm,
   output logic                 drive_overload_trip
);
   //////////////////////////////////////////////////////////////////////
   // Registers
   logic [2:0]          relay_sel_r;
   logic [MODE_W-1:0]   mode_r [NAUX];
   logic [FW-1:0]       fdt_freq_r;
   logic [FW-1:0]       fdt_band_r;
   logic [IW-1:0]       warn_current_level;
   logic [15:0]         warn_current_time;
   logic [IW-1:0]       rated_current_r;
   logic [FW-1:0]       start_frequency_setting;
   logic [15:0]         tick_cnt_r;
   logic                tick;
   logic [15:0]         warn_ms_r;
   logic                current_warn_flag;
   logic                relay_r;
   logic [NAUX-1:0]     cond;

   //////////////////////////////////////////////////////////////////////
   // Frequency windows
   logic [FW-1:0] half_band;
   logic [FW-1:0] gap_ref;
   logic [FW-1:0] gap_det;
   logic [FW-1:0] lower_lvl;
   logic          arrive_ok;
   logic          band_ok;
   logic          level_ok;
   logic          run_ok;
   logic          line_lock;

   assign half_band = fdt_band_r >> 1;
   assign gap_ref   = (ref_freq > out_freq) ? ref_freq - out_freq :
                      out_freq - ref_freq;
   assign gap_det   = (fdt_freq_r > out_freq) ? fdt_freq_r - out_freq :
                      out_freq - fdt_freq_r;
   assign lower_lvl = (fdt_freq_r > half_band) ? fdt_freq_r - half_band
                      : '0;
   assign arrive_ok = gap_ref <= half_band;
   assign band_ok   = gap_det <= half_band;
   assign level_ok  = accelerating ? (out_freq >= fdt_freq_r)
                      : (out_freq > lower_lvl);
   assign run_ok    = running && !dc_braking && !auto_tuning &&
                      (out_freq > start_frequency_setting ||
                       dc_start_preheat) && out_freq != '0;
   assign line_lock = running;
   assign speed_catch_setting = exchanging;

   //////////////////////////////////////////////////////////////////////
   // Contact selection per output
   for (genvar g = 0; g < NAUX; g++) begin : g_aux
      always_comb begin
         case (aux_mode_e'(mode_r[g]))
            M_ARRIVE:    cond[g] = arrive_ok;
            M_SPEC:      cond[g] = arrive_ok && band_ok;
            M_BAND:      cond[g] = band_ok;
            M_LEVEL:     cond[g] = level_ok;
            M_LEVEL_N:   cond[g] = !level_ok;
            M_WARN:      cond[g] = current_warn_flag;
            M_THERMAL:   cond[g] = drive_thermal_alarm;
            M_STALL:     cond[g] = stall_active;
            M_BUS_HI:    cond[g] = dc_bus_high_flag;
            M_BUS_LO:    cond[g] = dc_bus_low_flag;
            M_HOT:       cond[g] = heatsink_hot_flag;
            M_LOST:      cond[g] = ref_lost;
            M_RUN:       cond[g] = run_ok;
            M_STOP:      cond[g] = !running;
            M_STEADY:    cond[g] = at_steady;
            M_INV_LINE:  cond[g] = !exchanging && running;
            M_COMM_LINE: cond[g] = exchanging;
            M_SSEARCH:   cond[g] = speed_searching;
            M_READY:     cond[g] = ready_to_run;
            M_MULTI:     cond[g] = multi_motor_out;
            default:     cond[g] = 1'b0;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Warning time counts whole ticks; the first may fall at once
   assign tick = tick_cnt_r == 16'(TICK_CYC - 1);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt_r        <= '0;
         warn_ms_r         <= '0;
         current_warn_flag <= 1'b0;
         aux_contact       <= '0;
      end else begin
         tick_cnt_r <= tick ? '0 : tick_cnt_r + 16'h0001;
         if (out_current < warn_current_level) begin
            warn_ms_r <= '0;
         end else if (tick && warn_ms_r != 16'hffff) begin
            warn_ms_r <= warn_ms_r + 16'h0001;
         end
         current_warn_flag <= (out_current >= warn_current_level) &&
                              (warn_ms_r > warn_current_time);
         aux_contact <= cond;
      end
   end

   overload_timer #(
      .TRIP_MS (TRIP_MS)
   ) u_ovl (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .tick    (tick),
      .i_out   (out_current),
      .i_rated (rated_current_r),
      .alarm   (drive_thermal_alarm),
      .trip    (drive_overload_trip)
   );

   //////////////////////////////////////////////////////////////////////
   // Fault relay, checked in order LV, trip, retry
   logic relay_nxt;
   assign relay_nxt =
      (relay_sel_r[0] && fault_lv) ? 1'b1 :
      (relay_sel_r[1] && (fault_other || drive_overload_trip) &&
       !output_inhibit && !fault_lv) ? 1'b1 :
      (relay_sel_r[2] && retry_exhausted && !auto_retry_on);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         relay_r <= 1'b0;
      end else begin
         relay_r <= relay_nxt;
      end
   end
   assign fault_relay_no_side = relay_r;
   assign fault_relay_nc_side = !relay_r;

   //////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave; each channel taken when idle
   logic        aw_hold_r;
   logic        w_hold_r;
   logic [7:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        do_write;
   logic        wr_known;
   logic        rd_known;
   logic [31:0] rd_word;
   logic [31:0] status_word;

   assign s_awready = !aw_hold_r && !s_bvalid;
   assign s_wready  = !w_hold_r && !s_bvalid;
   assign s_arready = !s_rvalid;
   assign do_write  = aw_hold_r && w_hold_r;
   assign wr_known  = aw_addr_r == OFS_RELAY_SEL || aw_addr_r == OFS_AUX_MODE
                   || aw_addr_r == OFS_FDT || aw_addr_r == OFS_WARN
                   || aw_addr_r == OFS_RATED;
   assign status_word = {24'h0, relay_r, ctrl_outputs, aux_contact};

   always_comb begin
      rd_known = 1'b1;
      if (s_araddr == OFS_RELAY_SEL) rd_word = {29'h0, relay_sel_r};
      else if (s_araddr == OFS_AUX_MODE)
         rd_word = {3'h0, mode_r[3], 3'h0, mode_r[2],
                    3'h0, mode_r[1], 3'h0, mode_r[0]};
      else if (s_araddr == OFS_FDT) rd_word = {fdt_band_r, fdt_freq_r};
      else if (s_araddr == OFS_WARN)
         rd_word = {warn_current_time, warn_current_level};
      else if (s_araddr == OFS_STATUS) rd_word = status_word;
      else if (s_araddr == OFS_RATED)
         rd_word = {start_frequency_setting, rated_current_r};
      else begin
         rd_word  = '0;
         rd_known = 1'b0;
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
      return r;
   endfunction

   logic [31:0] cur_word;
   logic [31:0] new_word;
   assign cur_word = (aw_addr_r == OFS_RELAY_SEL) ? {29'h0, relay_sel_r} :
      (aw_addr_r == OFS_AUX_MODE) ? {3'h0, mode_r[3], 3'h0, mode_r[2],
                                     3'h0, mode_r[1], 3'h0, mode_r[0]} :
      (aw_addr_r == OFS_FDT) ? {fdt_band_r, fdt_freq_r} :
      (aw_addr_r == OFS_WARN) ? {warn_current_time, warn_current_level} :
      {start_frequency_setting, rated_current_r};
   assign new_word = merge(cur_word, w_data_r, w_strb_r);

   // Exchange modes may not be entered or left by a write while the drive runs
   function automatic logic is_line(input logic [MODE_W-1:0] m);
      return m == M_INV_LINE || m == M_COMM_LINE;
   endfunction

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         aw_addr_r <= '0;
         w_data_r  <= '0;
         w_strb_r  <= '0;
         s_bvalid  <= 1'b0;
         s_bresp   <= RESP_OKAY;
         s_rvalid  <= 1'b0;
         s_rdata   <= '0;
         s_rresp   <= RESP_OKAY;
         relay_sel_r <= RELAY_SEL_RST;
         for (int k = 0; k < NAUX; k++) mode_r[k] <= M_NONE;
         fdt_freq_r <= '0;
         fdt_band_r <= '0;
         warn_current_level <= '1;
         warn_current_time  <= '0;
         rated_current_r    <= '0;
         start_frequency_setting <= '0;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_wdata;
            w_strb_r <= s_wstrb;
         end
         if (do_write) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            s_bvalid  <= 1'b1;
            s_bresp   <= wr_known ? RESP_OKAY : RESP_SLVERR;
            if (aw_addr_r == OFS_RELAY_SEL) relay_sel_r <= new_word[2:0];
            else if (aw_addr_r == OFS_AUX_MODE) begin
               for (int k = 0; k < NAUX; k++)
                  if (!(line_lock && (is_line(mode_r[k]) ||
                        is_line(new_word[k*8 +: MODE_W]))))
                     mode_r[k] <= new_word[k*8 +: MODE_W];
            end
            else if (aw_addr_r == OFS_FDT) begin
               fdt_freq_r <= new_word[15:0];
               fdt_band_r <= new_word[31:16];
            end
            else if (aw_addr_r == OFS_WARN) begin
               warn_current_level <= new_word[15:0];
               warn_current_time  <= new_word[31:16];
            end
            else if (aw_addr_r == OFS_RATED) begin
               rated_current_r         <= new_word[15:0];
               start_frequency_setting <= new_word[31:16];
            end
         end else if (multi_motor_sel) begin
            mode_r[NAUX-1] <= M_MULTI;
         end
         if (s_bvalid && s_bready) s_bvalid <= 1'b0;
         if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata  <= rd_word;
            s_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   relay_pair_a: assert property (fault_relay_no_side != fault_relay_nc_side)
      else $error("relay pairs not complementary");
   relay_lv_a: assert property (relay_sel_r[0] && fault_lv |=> relay_r)
      else $error("lv trip missed");
   relay_inhibit_a: assert property (!relay_sel_r[0] && !relay_sel_r[2] &&
      output_inhibit |=> !relay_r) else $error("inhibit relayed");
   relay_retry_a: assert property (relay_sel_r == RELAY_BIT_RETRY &&
      auto_retry_on |=> !relay_r) else $error("retry while auto");
   contact_follow_a: assert property (##1 aux_contact == $past(cond))
      else $error("contact lags");
   band_mode_a: assert property (mode_r[0] == M_BAND && $stable(mode_r[0])
      && gap_det > half_band |=> !aux_contact[0])
      else $error("band open missed");
   level_inv_a: assert property (mode_r[0] == M_LEVEL_N &&
      $stable(mode_r[0]) |=> aux_contact[0] == !$past(level_ok))
      else $error("inverted level wrong");
   status_bits_a: assert property (status_word[7] == relay_r)
      else $error("status relay bit");
   speed_catch_a: assert property (exchanging |-> speed_catch_setting)
      else $error("speed catch off");
endmodule // aux_contact_condition_select

// ==== test/plant_wiring_model.sv ====
// Purpose: Plant wiring seen by the fault relay contact pairs
// Assumes: Relay pairs are dry contacts read by plant equipment
// Notes:   Flags a pair that fails to swap with its partner
`timescale 1ns/1ns
module plant_wiring_model (
   // Relay pairs
   input  wire logic no_side,
   input  wire logic nc_side,
   // Wiring health
   output logic      pair_ok
);
   // Both pairs must change together or plant interlocks misread
   assign pair_ok = no_side ^ nc_side;
endmodule // plant_wiring_model

// ==== test/aux_contact_condition_select_test.sv ====
// Purpose: Self-checking bench for the auxiliary contact logic
// Assumes: Overload trip time shortened to 10 ms
// Notes:   Drive state is randomised; expectations come from the model
`timescale 1ns/1ns
module aux_contact_condition_select_test;
   import aux_pkg::*;
   localparam int DET = 3000;
   localparam int HB  = 500;
   logic ref_clk = 0, nrst = 0, s_awvalid = 0, s_wvalid = 0, s_arvalid = 0;
   logic s_bready = 1, s_rready = 1, s_awready, s_wready, s_bvalid;
   logic s_arready, s_rvalid, pair_ok, no_s, nc_s, catch_s, alarm, trip;
   logic [7:0] s_awaddr = 0, s_araddr = 0;
   logic [31:0] s_wdata = 0, s_rdata;
   logic [3:0] s_wstrb = 4'hf, aux;
   logic [1:0] s_bresp, s_rresp, last_bresp;
   logic [15:0] ref_freq = 0, out_freq = 0, out_current = 0;
   logic [2:0] ctrl_outputs = 0;
   logic acc = 0, stall = 0, hi = 0, lo = 0, hot = 0, lost = 0, run = 0;
   logic brk = 0, pre = 0, tun = 0, stdy = 0, rdy = 0, srch = 0, exch = 0;
   logic lv = 0, oth = 0, inh = 0, rex = 0, aro = 0, mms = 0, mmo = 0;
   int errors = 0, compares = 0;
   always #50 ref_clk = ~ref_clk;
   aux_contact_condition_select #(.TRIP_MS(10)) aux_contact_condition_select_inst (
      .ref_clk, .nrst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
      .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
      .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
      .ref_freq, .out_freq, .accelerating(acc), .out_current,
      .stall_active(stall), .dc_bus_high_flag(hi), .dc_bus_low_flag(lo),
      .heatsink_hot_flag(hot), .ref_lost(lost), .running(run),
      .dc_braking(brk), .dc_start_preheat(pre), .auto_tuning(tun),
      .at_steady(stdy), .ready_to_run(rdy), .speed_searching(srch),
      .exchanging(exch), .multi_motor_sel(mms), .multi_motor_out(mmo),
      .ctrl_outputs, .fault_lv(lv), .fault_other(oth), .output_inhibit(inh),
      .retry_exhausted(rex), .auto_retry_on(aro), .aux_contact(aux),
      .fault_relay_no_side(no_s), .fault_relay_nc_side(nc_s),
      .speed_catch_setting(catch_s), .drive_thermal_alarm(alarm),
      .drive_overload_trip(trip));
   plant_wiring_model plant_wiring_model_inst (
      .no_side(no_s), .nc_side(nc_s), .pair_ok(pair_ok));
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (e !== g) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic aw, w;
      aw = 0;
      w = 0;
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1;
      s_wvalid <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (!aw && s_awready) begin aw = 1; s_awvalid <= 0; end
         if (!w && s_wready) begin w = 1; s_wvalid <= 0; end
         if (s_bvalid === 1'b1) begin last_bresp = s_bresp; break; end
      end
      if (n == 50) begin errors++; report_and_stop; end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      s_araddr <= a;
      s_arvalid <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (s_arvalid && s_arready) s_arvalid <= 0;
         if (s_rvalid === 1'b1) begin d = s_rdata; r = s_rresp; break; end
      end
      if (n == 50) begin errors++; report_and_stop; end
   endtask
   // Random drive state; currents stay below the overload threshold
   task automatic rnd;
      logic [31:0] r, q;
      r = $urandom;
      q = $urandom;
      {stall, hi, lo, hot, lost, run, brk, pre, tun, stdy, rdy, srch} <= r[11:0];
      {exch, acc, lv, inh, rex, aro} <= r[17:12];
      oth <= r[18] & ~r[14];
      ctrl_outputs <= r[21:19];
      out_freq <= 16'd2000 + {6'h0, r[31:22]} * 16'd2;
      ref_freq <= 16'd2000 + {5'h0, q[10:0]};
      out_current <= {10'h0, q[16:11]};
      repeat (2) @(posedge ref_clk);
   endtask
   function automatic logic exp_c(input int m);
      int o, d1, d2;
      logic lvl;
      o = out_freq;
      d1 = int'(ref_freq) - o;
      d2 = DET - o;
      lvl = acc ? (o >= DET) : (o > DET - HB);
      case (m)
         1: return (d1 < 0 ? -d1 : d1) <= HB;
         2: return (d1 < 0 ? -d1 : d1) <= HB && (d2 < 0 ? -d2 : d2) <= HB;
         3: return (d2 < 0 ? -d2 : d2) <= HB;
         4: return lvl;
         5: return !lvl;
         8: return stall;
         9: return hi;
         10: return lo;
         11: return hot;
         12: return lost;
         13: return run && (o > 3000 || pre) && !brk && !tun;
         14: return !run;
         15: return stdy;
         16: return !exch && run;
         17: return exch;
         18: return srch;
         19: return rdy;
         default: return 0;
      endcase
   endfunction
   function automatic logic exp_r(input logic [2:0] s);
      return (s[0] & lv) | (s[1] & oth & ~inh & ~lv) | (s[2] & rex & ~aro);
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int i, k, a;
      int cm[4] = '{3, 1, 4, 5};
      int fm[15] = '{2, 16, 17, 4, 5, 8, 9, 10, 11, 12, 13, 14, 15, 18, 19};
      logic [31:0] d;
      logic [1:0] rs;
      void'($urandom(32'h2156));
      repeat (3) @(posedge ref_clk);
      nrst <= 1;
      @(posedge ref_clk);
      rd(OFS_RELAY_SEL, d, rs);
      chk("relay_sel_reset", {29'h0, RELAY_SEL_RST}, d);
      rd(8'h20, d, rs);
      chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      wr(8'h20, 32'h0);
      chk("unmapped_wresp", {30'h0, RESP_SLVERR}, {30'h0, last_bresp});
      wr(OFS_FDT, {16'd1000, 16'd3000});
      wr(OFS_RATED, {16'd3000, 16'd64});
      wr(OFS_AUX_MODE, 32'h05040103);
      for (i = 0; i < 40; i++) begin
         rnd;
         for (k = 0; k < 4; k++) chk("window", exp_c(cm[k]), aux[k]);
         chk("speed_catch", exch, catch_s);
      end
      for (i = 0; i < 15; i++) begin
         run <= 0;
         wr(OFS_AUX_MODE, {24'h050401, 8'(fm[i])});
         for (k = 0; k < 6; k++) begin
            rnd;
            chk("flag_mode", exp_c(fm[i]), aux[0]);
         end
      end
      run <= 1;
      wr(OFS_AUX_MODE, 32'h05040110);
      rd(OFS_AUX_MODE, d, rs);
      chk("line_lock", 32'h05040113, d);
      for (i = 0; i < 8; i++) begin
         wr(OFS_RELAY_SEL, 32'(i));
         for (k = 0; k < 4; k++) begin
            rnd;
            chk("relay", exp_r(3'(i)), no_s);
            chk("pair", 1, pair_ok);
         end
         rd(OFS_STATUS, d, rs);
         chk("status", {exp_r(3'(i)), ctrl_outputs, exp_c(5), exp_c(4),
             exp_c(1), exp_c(19)}, d[7:0]);
      end
      {lv, oth, rex, inh} <= 0;
      out_current <= 16'd63;
      wr(OFS_WARN, {16'd1, 16'd60});
      wr(OFS_AUX_MODE, 32'h05040106);
      repeat (5000) @(posedge ref_clk);
      chk("warn_early", 0, aux[0]);
      repeat (20000) @(posedge ref_clk);
      chk("warn_late", 1, aux[0]);
      wr(OFS_RELAY_SEL, 32'h2);
      wr(OFS_AUX_MODE, 32'h05040107);
      out_current <= 16'd102;
      a = 0;
      for (i = 0; i < 80000 && trip !== 1'b1; i++) begin
         @(posedge ref_clk);
         if (alarm === 1'b1) a++;
      end
      if (i == 80000) begin errors++; report_and_stop; end
      // Alarm should lead the trip by about two fifths of the trip time
      chk("alarm_share", 1, a * 10 >= i * 3 && a * 10 <= i * 5);
      repeat (2) @(posedge ref_clk);
      chk("thermal_contact", 1, aux[0]);
      chk("trip_relay", 1, no_s);
      out_current <= 0;
      repeat (3) @(posedge ref_clk);
      chk("trip_sticky", 1, trip);
      {mms, mmo} <= 2'b11;
      repeat (3) @(posedge ref_clk);
      chk("multi_contact", 1, aux[3]);
      rd(OFS_AUX_MODE, d, rs);
      chk("multi_mode", {27'h0, M_MULTI}, {27'h0, d[28:24]});
      report_and_stop;
   end
endmodule // aux_contact_condition_select_test
